// File: hdl/rfo_pkg.sv
package rfo_pkg;

  // ==========================================================
  // Register bus
  // ==========================================================
  localparam int         AV_ADDR_W      = 4;
  localparam int         AV_DATA_W      = 32;
  localparam logic [3:0] OFS_WSCTL      = 4'h0;
  localparam logic [3:0] OFS_STATUS     = 4'h4;

  // ==========================================================
  // Wait-state control register
  // ==========================================================
  localparam int         WSCTL_W        = 8;
  localparam logic [7:0] WSCTL_INIT     = 8'h08;
  localparam int         BIT_SIZE_SEL   = 7;
  localparam int         BIT_BASE_SEL   = 6;

  // Status register bit positions
  localparam int         STAT_ACTIVE    = 0;
  localparam int         STAT_PROTECT   = 1;
  localparam int         STAT_WRITER    = 2;

  // ==========================================================
  // Overlap select codes {size, base}
  // ==========================================================
  localparam logic [1:0] OVL_NONE       = 2'h0;
  localparam logic [1:0] OVL_SB_HI      = 2'h1;
  localparam logic [1:0] OVL_WIDE       = 2'h2;
  localparam logic [1:0] OVL_SB_LO      = 2'h3;

  // ==========================================================
  // Address map
  // ==========================================================
  localparam int          MEM_ADDR_W    = 16;
  localparam int          RAM_OFS_W     = 9;
  localparam logic [15:0] RAM_BASE      = 16'hf800;
  localparam logic [15:0] RAM_LAST      = 16'hf97f;
  localparam logic [15:0] FLASH_LAST    = 16'hef7f;

  localparam logic [15:0] SB_HI_ROM_LO  = 16'h0080;
  localparam logic [15:0] SB_HI_ROM_HI  = 16'h00ff;
  localparam logic [15:0] SB_HI_RAM_LO  = 16'hf880;
  localparam logic [15:0] WIDE_ROM_LO   = 16'h0080;
  localparam logic [15:0] WIDE_ROM_HI   = 16'h017f;
  localparam logic [15:0] WIDE_RAM_LO   = 16'hf880;
  localparam logic [15:0] SB_LO_ROM_LO  = 16'h0000;
  localparam logic [15:0] SB_LO_ROM_HI  = 16'h007f;
  localparam logic [15:0] SB_LO_RAM_LO  = 16'hf800;

  // ==========================================================
  // Bus handshake states
  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANS  = 2'b10
  } rfo_bus_st_t;

endpackage : rfo_pkg

// File: hdl/rfo_decode.sv
`timescale 1ns/100ps

module rfo_decode #(
  parameter logic [15:0] P_FLASH_LAST = rfo_pkg::FLASH_LAST
) (
  // CPU address and mode
  input  wire logic [15:0] i_addr,
  input  wire logic [1:0]  i_code,
  input  wire logic        i_writer,
  // Steering result
  output logic             o_to_ram,
  output logic             o_to_flash,
  output logic             o_alias,
  output logic [8:0]       o_ram_off
);

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic [15:0] win_lo;
  logic [15:0] win_hi;
  logic [15:0] ram_lo;
  logic [15:0] off16;
  logic        native;

  // ==========================================================
  // Overlap window per select code
  // ==========================================================
  always_comb begin
    win_lo  = rfo_pkg::SB_HI_ROM_LO;
    win_hi  = rfo_pkg::SB_HI_ROM_HI;
    ram_lo  = rfo_pkg::SB_HI_RAM_LO;
    o_alias = 1'b0;
    case (i_code)
      rfo_pkg::OVL_SB_HI: begin
        win_lo  = rfo_pkg::SB_HI_ROM_LO;
        win_hi  = rfo_pkg::SB_HI_ROM_HI;
        ram_lo  = rfo_pkg::SB_HI_RAM_LO;
        o_alias = in_range(i_addr, win_lo, win_hi);
      end
      rfo_pkg::OVL_WIDE: begin
        win_lo  = rfo_pkg::WIDE_ROM_LO;
        win_hi  = rfo_pkg::WIDE_ROM_HI;
        ram_lo  = rfo_pkg::WIDE_RAM_LO;
        o_alias = in_range(i_addr, win_lo, win_hi);
      end
      rfo_pkg::OVL_SB_LO: begin
        win_lo  = rfo_pkg::SB_LO_ROM_LO;
        win_hi  = rfo_pkg::SB_LO_ROM_HI;
        ram_lo  = rfo_pkg::SB_LO_RAM_LO;
        o_alias = in_range(i_addr, win_lo, win_hi);
      end
      default: o_alias = 1'b0; // No overlap
    endcase
    // The external programmer owns the flash array in writer mode
    if (i_writer) begin
      o_alias = 1'b0;
    end
  end

  // ==========================================================
  // Steering
  // ==========================================================
  always_comb begin
    native = in_range(i_addr, rfo_pkg::RAM_BASE,
                      rfo_pkg::RAM_LAST);
    if (o_alias) begin
      off16 = i_addr - win_lo + ram_lo - rfo_pkg::RAM_BASE;
    end else begin
      off16 = i_addr - rfo_pkg::RAM_BASE;
    end
    o_ram_off  = off16[8:0];
    o_to_ram   = o_alias || native;
    o_to_flash = !o_to_ram && (i_addr <= P_FLASH_LAST);
  end

endmodule : rfo_decode

// File: hdl/rfo_remap.sv
`timescale 1ns/100ps

module rfo_remap #(
  parameter logic [15:0] P_FLASH_LAST = rfo_pkg::FLASH_LAST
) (
  // Clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SYS_RST,
  // Power modes
  input  wire logic        I_HW_STANDBY,
  input  wire logic        I_SW_STANDBY,
  input  wire logic        I_WRITER_MODE,
  // Avalon-MM slave
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  input  wire logic [3:0]  I_AVS_BYTEENABLE,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  // CPU memory request
  input  wire logic [15:0] I_CPU_ADDR,
  input  wire logic        I_CPU_RD,
  input  wire logic        I_CPU_WR,
  input  wire logic [7:0]  I_CPU_WDATA,
  // Steered memory access
  output logic             O_RAM_SEL,
  output logic      [8:0]  O_RAM_ADDR,
  output logic             O_FLASH_SEL,
  output logic      [15:0] O_FLASH_ADDR,
  output logic             O_MEM_RD,
  output logic             O_MEM_WR,
  output logic      [7:0]  O_MEM_WDATA,
  // Status
  output logic      [1:0]  O_OVERLAP_CODE,
  output logic             O_FLASH_PGM_BLOCK
);

  rfo_pkg::rfo_bus_st_t state;
  rfo_pkg::rfo_bus_st_t next_state;

  logic [7:0] wait_state_control;
  logic [1:0] sel_code;
  logic       req;
  logic       take_write;
  logic       wsctl_hit;
  logic       dec_ram;
  logic       dec_flash;
  logic       dec_alias;
  logic [8:0] dec_off;
  logic       cpu_req;

  assign sel_code = {wait_state_control[rfo_pkg::BIT_SIZE_SEL],
                     wait_state_control[rfo_pkg::BIT_BASE_SEL]};
  assign req        = I_AVS_READ || I_AVS_WRITE;
  assign wsctl_hit  = (I_AVS_ADDRESS == rfo_pkg::OFS_WSCTL);
  // A write lands only at the edge where waitrequest is seen low
  assign take_write = I_AVS_WRITE && (state == rfo_pkg::ST_ANS);
  assign cpu_req    = I_CPU_RD || I_CPU_WR;

  // ==========================================================
  // Bus handshake
  // ==========================================================
  always_comb begin
    next_state = rfo_pkg::ST_IDLE;
    case (state)
      rfo_pkg::ST_IDLE: begin
        if (req) begin
          next_state = rfo_pkg::ST_ANS;
        end
      end
      rfo_pkg::ST_ANS: next_state = rfo_pkg::ST_IDLE;
      default:         next_state = rfo_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state             <= rfo_pkg::ST_IDLE;
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      state             <= next_state;
      O_AVS_WAITREQUEST <= (next_state != rfo_pkg::ST_ANS);
    end
  end

  // Read data are captured when the request is first seen
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_AVS_READDATA <= 32'h0;
    end else if (I_AVS_READ && state == rfo_pkg::ST_IDLE) begin
      if (wsctl_hit) begin
        O_AVS_READDATA <= {24'h0, wait_state_control};
      end else if (I_AVS_ADDRESS == rfo_pkg::OFS_STATUS) begin
        O_AVS_READDATA <= 32'h0;
        O_AVS_READDATA[rfo_pkg::STAT_ACTIVE]  <= (sel_code !=
                                                 rfo_pkg::OVL_NONE);
        O_AVS_READDATA[rfo_pkg::STAT_PROTECT] <= ^sel_code;
        O_AVS_READDATA[rfo_pkg::STAT_WRITER]  <= I_WRITER_MODE;
      end else begin
        O_AVS_READDATA <= 32'h0;
      end
    end
  end

  // ==========================================================
  // Wait-state control register
  // ==========================================================
  // Software standby is deliberately not a term here: the register
  // must come out of it with the overlap still in place.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wait_state_control <= rfo_pkg::WSCTL_INIT;
    end else if (I_HW_STANDBY) begin
      wait_state_control <= rfo_pkg::WSCTL_INIT;
    end else if (take_write && wsctl_hit && I_AVS_BYTEENABLE[0]) begin
      wait_state_control <= I_AVS_WRITEDATA[7:0];
    end
  end

  // ==========================================================
  // Address steering
  // ==========================================================
  rfo_decode #(
    .P_FLASH_LAST (P_FLASH_LAST)
  ) u_decode (
    .i_addr     (I_CPU_ADDR),
    .i_code     (sel_code),
    .i_writer   (I_WRITER_MODE),
    .o_to_ram   (dec_ram),
    .o_to_flash (dec_flash),
    .o_alias    (dec_alias),
    .o_ram_off  (dec_off)
  );

  // One cycle of latency buys clean registered strobes to the arrays
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RAM_SEL    <= 1'b0;
      O_RAM_ADDR   <= 9'h0;
      O_FLASH_SEL  <= 1'b0;
      O_FLASH_ADDR <= 16'h0;
      O_MEM_RD     <= 1'b0;
      O_MEM_WR     <= 1'b0;
      O_MEM_WDATA  <= 8'h0;
    end else begin
      O_RAM_SEL    <= cpu_req && dec_ram;
      O_RAM_ADDR   <= dec_off;
      O_FLASH_SEL  <= cpu_req && dec_flash;
      O_FLASH_ADDR <= I_CPU_ADDR;
      O_MEM_RD     <= I_CPU_RD;
      O_MEM_WR     <= I_CPU_WR;
      O_MEM_WDATA  <= I_CPU_WDATA;
    end
  end

  // Exactly one select bit set locks flash program and erase
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_OVERLAP_CODE    <= rfo_pkg::OVL_NONE;
      O_FLASH_PGM_BLOCK <= 1'b0;
    end else begin
      O_OVERLAP_CODE    <= sel_code;
      O_FLASH_PGM_BLOCK <= ^sel_code;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  select_bits_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    take_write && wsctl_hit && I_AVS_BYTEENABLE[0] && !I_HW_STANDBY
    |=> ##1 O_OVERLAP_CODE == $past(I_AVS_WRITEDATA[7:6], 2))
    else $error("overlap code does not follow written select bits");

  native_ram_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    cpu_req && I_CPU_ADDR >= rfo_pkg::RAM_BASE
    && I_CPU_ADDR <= rfo_pkg::RAM_LAST
    |=> O_RAM_SEL && !O_FLASH_SEL
        && O_RAM_ADDR == 9'($past(I_CPU_ADDR) - rfo_pkg::RAM_BASE))
    else $error("native RAM address not steered to RAM");

  sb_hi_map_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    cpu_req && !I_WRITER_MODE && sel_code == rfo_pkg::OVL_SB_HI
    && I_CPU_ADDR >= rfo_pkg::SB_HI_ROM_LO
    && I_CPU_ADDR <= rfo_pkg::SB_HI_ROM_HI
    |=> O_RAM_SEL && O_RAM_ADDR == 9'($past(I_CPU_ADDR)
        - rfo_pkg::SB_HI_ROM_LO + rfo_pkg::SB_HI_RAM_LO
        - rfo_pkg::RAM_BASE))
    else $error("code 01 alias maps to wrong RAM byte");

  no_overlap_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    cpu_req && sel_code == rfo_pkg::OVL_NONE
    && I_CPU_ADDR <= rfo_pkg::WIDE_ROM_HI
    |=> O_FLASH_SEL && !O_RAM_SEL)
    else $error("flash access diverted with no overlap selected");

  alias_steer_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    cpu_req && dec_alias |=> O_RAM_SEL && !O_FLASH_SEL
    && O_MEM_WR == $past(I_CPU_WR))
    else $error("alias access reached the flash array");

  reg_init_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    I_HW_STANDBY |=> wait_state_control == rfo_pkg::WSCTL_INIT
    ##1 O_OVERLAP_CODE == rfo_pkg::OVL_NONE)
    else $error("hardware standby did not reload wait-state register");

  sw_keep_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    I_SW_STANDBY && !I_HW_STANDBY && !take_write
    |=> $stable(wait_state_control))
    else $error("software standby disturbed wait-state register");

  writer_flash_a: assert property (
    @(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    cpu_req && I_WRITER_MODE && I_CPU_ADDR <= P_FLASH_LAST
    |=> O_FLASH_SEL && !O_RAM_SEL)
    else $error("writer mode access not sent to flash");

  bus_answer_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("register bus answer not given after one wait cycle");

endmodule : rfo_remap

// File: bench/rfo_cpu_model.sv
`timescale 1ns/100ps
// ======================================
// CPU side of the memory path
module rfo_cpu_model (
  // Clock
  input  wire logic        i_clk,
  // CPU request
  output logic      [15:0] o_addr,
  output logic             o_rd,
  output logic             o_wr,
  output logic      [7:0]  o_wdata
);
  initial begin
    o_addr  = 16'h0;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 8'h0;
  end

  // This CPU never starts a flash program or erase, so the
  // watchdog duty does not arise here
  // One-cycle access; released address and data lines show the inverse so that a
  // stale copy in the steering cannot pass for a fresh one
  task automatic access(input logic [15:0] a, input logic w,
                        input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_rd    <= !w;
    o_wr    <= w;
    o_wdata <= d;
    @(posedge i_clk);
    o_addr  <= ~a;
    o_rd    <= 1'b0;
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask : access
endmodule : rfo_cpu_model

// File: bench/tb_ram_flash_overlap_remap.sv
`timescale 1ns/100ps
module tb_ram_flash_overlap_remap;
  // ======================================
  // Signals
  logic        clk, rst, hw_sb, sw_sb, wr_mode;
  logic        av_rd, av_wr, av_wait, cpu_rd, cpu_wr;
  logic        ram_sel, fl_sel, mem_rd, mem_wr, pgm_blk;
  logic [3:0]  av_addr, av_be;
  logic [31:0] av_wdata, av_rdata, rdv;
  logic [15:0] cpu_addr, fl_addr;
  logic [7:0]  cpu_wdata, mem_wdata;
  logic [8:0]  ram_addr;
  logic [1:0]  ovl_code, cur;
  int          n_mismatch = 0, tests_run = 0;
  typedef struct packed {
    logic [1:0]  code;
    logic [15:0] addr;
    logic        ram;
    logic [8:0]  off;
    logic        fl;
  } rfo_row_t;
  rfo_row_t    rows [14];

  rfo_remap i_dut (
    .I_CLK_SYS        (clk),
    .I_SYS_RST        (rst),
    .I_HW_STANDBY     (hw_sb),
    .I_SW_STANDBY     (sw_sb),
    .I_WRITER_MODE    (wr_mode),
    .I_AVS_ADDRESS    (av_addr),
    .I_AVS_READ       (av_rd),
    .I_AVS_WRITE      (av_wr),
    .I_AVS_WRITEDATA  (av_wdata),
    .I_AVS_BYTEENABLE (av_be),
    .O_AVS_READDATA   (av_rdata),
    .O_AVS_WAITREQUEST(av_wait),
    .I_CPU_ADDR       (cpu_addr),
    .I_CPU_RD         (cpu_rd),
    .I_CPU_WR         (cpu_wr),
    .I_CPU_WDATA      (cpu_wdata),
    .O_RAM_SEL        (ram_sel),
    .O_RAM_ADDR       (ram_addr),
    .O_FLASH_SEL      (fl_sel),
    .O_FLASH_ADDR     (fl_addr),
    .O_MEM_RD         (mem_rd),
    .O_MEM_WR         (mem_wr),
    .O_MEM_WDATA      (mem_wdata),
    .O_OVERLAP_CODE   (ovl_code),
    .O_FLASH_PGM_BLOCK(pgm_blk)
  );

  rfo_cpu_model i_cpu (
    .i_clk  (clk),
    .o_addr (cpu_addr),
    .o_rd   (cpu_rd),
    .o_wr   (cpu_wr),
    .o_wdata(cpu_wdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ======================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Request held until waitrequest is seen low at a rising edge
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk);
    av_rd    <= !w;
    av_wr    <= w;
    av_addr  <= a;
    av_wdata <= {24'h0, d};
    av_be    <= be;
    do begin
      @(posedge clk);
      k++;
    end while (av_wait !== 1'b0 && k < 20);
    rdv = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (av_wait !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : av

  // ======================================
  // Sequence
  initial begin
    rst = 1'b1;
    hw_sb = 1'b0;
    sw_sb = 1'b0;
    wr_mode = 1'b0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_addr = 4'h0;
    av_wdata = 32'h0;
    av_be = 4'h0;
    rows = '{'{2'h0,16'h0085,1'b0,9'h000,1'b1},
             '{2'h0,16'hf97f,1'b1,9'h17f,1'b0},
             '{2'h0,16'hef80,1'b0,9'h000,1'b0},
             '{2'h1,16'h0080,1'b1,9'h080,1'b0},
             '{2'h1,16'h00ff,1'b1,9'h0ff,1'b0},
             '{2'h1,16'h0100,1'b0,9'h000,1'b1},
             '{2'h1,16'hf8ff,1'b1,9'h0ff,1'b0},
             '{2'h2,16'h017f,1'b1,9'h17f,1'b0},
             '{2'h2,16'h0080,1'b1,9'h080,1'b0},
             '{2'h2,16'h0180,1'b0,9'h000,1'b1},
             '{2'h3,16'h0000,1'b1,9'h000,1'b0},
             '{2'h3,16'h007f,1'b1,9'h07f,1'b0},
             '{2'h3,16'h0080,1'b0,9'h000,1'b1},
             '{2'h3,16'hf980,1'b0,9'h000,1'b0}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, 4'h0, 8'h0, 4'h0);
    chk("wsctl", rdv, 32'h08);
    av(1'b0, 4'h8, 8'h0, 4'h0);
    chk("unmapped", rdv, 32'h0);
    cur = 2'h0;
    foreach (rows[i]) begin
      if (rows[i].code !== cur) begin
        cur = rows[i].code;
        av(1'b1, 4'h0, {cur, 6'h08}, 4'h1);
        @(posedge clk);
        #1;
        chk("code", ovl_code, cur);
        chk("pgm_blk", pgm_blk, cur == 2'h1 || cur == 2'h2);
      end
      // Odd rows write, even rows read
      i_cpu.access(rows[i].addr, i[0], 8'h3c);
      #1;
      chk("ram_sel", ram_sel, rows[i].ram);
      chk("fl_sel", fl_sel, rows[i].fl);
      if (rows[i].ram) chk("ram_addr", ram_addr, rows[i].off);
      if (rows[i].fl) chk("fl_addr", fl_addr, rows[i].addr);
      chk("mem_wr", mem_wr, i[0]);
      chk("mem_rd", mem_rd, !i[0]);
      chk("mem_wdata", mem_wdata, 8'h3c);
    end
    @(posedge clk);
    wr_mode <= 1'b1;
    i_cpu.access(16'h0000, 1'b0, 8'h0);
    #1;
    chk("writer", fl_sel, 1'b1);
    chk("writer_ram", ram_sel, 1'b0);
    av(1'b0, 4'h4, 8'h0, 4'h0);
    chk("status_wr", rdv, 32'h5);
    @(posedge clk);
    wr_mode <= 1'b0;
    sw_sb <= 1'b1;
    repeat (4) @(posedge clk);
    sw_sb <= 1'b0;
    av(1'b0, 4'h0, 8'h0, 4'h0);
    chk("sw_stby", rdv, 32'hc8);
    @(posedge clk);
    hw_sb <= 1'b1;
    av(1'b1, 4'h0, 8'h40, 4'h1);
    @(posedge clk);
    hw_sb <= 1'b0;
    av(1'b0, 4'h0, 8'h0, 4'h0);
    chk("hw_stby", rdv, 32'h08);
    // Tune through the alias, release, then read the native copy
    av(1'b1, 4'h0, 8'h48, 4'h1);
    av(1'b0, 4'h4, 8'h0, 4'h0);
    chk("status_01", rdv, 32'h3);
    i_cpu.access(16'h0085, 1'b1, 8'ha5);
    #1;
    chk("alias_wr", ram_addr, 9'h085);
    chk("alias_ram", ram_sel, 1'b1);
    chk("alias_fl", fl_sel, 1'b0);
    chk("alias_mem_wr", mem_wr, 1'b1);
    av(1'b1, 4'h0, 8'h08, 4'h1);
    i_cpu.access(16'hf885, 1'b0, 8'h0);
    #1;
    chk("native", ram_addr, 9'h085);
    i_cpu.access(16'h0085, 1'b0, 8'h0);
    #1;
    chk("released", fl_sel, 1'b1);
    av(1'b1, 4'h0, 8'hc8, 4'h1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk("rst_code", ovl_code, 2'h0);
    chk("rst_pgm", pgm_blk, 1'b0);
    chk("rst_wait", av_wait, 1'b1);
    @(posedge clk);
    rst <= 1'b0;
    av(1'b0, 4'h0, 8'h0, 4'h0);
    chk("rst_ws", rdv, 32'h08);
    give_verdict();
  end
endmodule : tb_ram_flash_overlap_remap
